// ### src/ctc_trigger_ctrl.sv
// trigger controller top: apb registers, trigger qualification, exposure sequencing, strobes
// Behaviour
// - trigger from one of five selectable sources
// - triggered mode waits; free-run captures continuously
// - standard mode: readout only after exposure ends
// - in triggered mode, fast mode overlaps next exposure with readout
// - edge setting picks rising or falling edge
// - ignore overlap drops triggers during a cycle
// - accept overlap aborts and restarts the cycle
// - debounce time blocks triggers after acceptance
// - pulses shorter than glitch minimum are rejected
// - exposure starts after programmable delay from edge
// - standard mode exposes programmed frames or endless
// - strobe mode selects none, one, two, both
// - strobe starts after programmable delay from edge
// - software command triggers when software source chosen
// - ready output shows next trigger acceptable
// - delayed output replays trigger shifted by delay
//
// Implementation choices: the placing of the registers and register access over APB.
module ctc_trigger_ctrl (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic ext1_trig_in,
  input wire logic ext2_trig_in,
  input wire logic host_cc1_in,
  input wire logic pulse_gen_in,
  input wire logic readout_done_in,
  output logic exposure_out,
  output logic readout_start_out,
  output logic strobe1_out,
  output logic strobe2_out,
  output logic trig_ready_out,
  output logic trig_delayed_out
);
  import ctc_pkg::*;

  logic tick;
  logic [2:0] pins;
  logic [CTRL_BITS-1:0] ctrl;
  logic [15:0] debounce_us;
  logic [15:0] glitch_us;
  logic [23:0] exp_delay_us;
  logic [15:0] frames;
  logic [23:0] strobe_delay_us;
  logic [23:0] exp_time_us;
  logic sw_pulse;
  ctc_state_t st;
  logic [23:0] cyc_us;
  logic [23:0] exp_us;
  logic [15:0] frame_cnt;
  logic [15:0] deb_us;
  logic deb_busy;
  logic lvl;
  logic lvl_prev;
  logic pend;
  logic [15:0] wid_us;
  logic qual;
  logic trig_ev;
  logic accept;
  logic acc_live;
  logic [15:0] held_w;
  logic dly_on;
  logic [15:0] dly_cnt;
  logic stb_armed;
  logic stb_on;
  logic [15:0] stb_cnt;
  logic trig_mode;
  logic more_frames;
  logic wr_en;
  ctc_src_t src;
  ctc_stb_t stb_mode;

  // adds one microsecond, holding at the top so long waits never wrap
  function automatic logic [23:0] sat_inc24(input logic [23:0] v);
    sat_inc24 = (v == 24'hffffff) ? v : v + 24'h000001;
  endfunction : sat_inc24

  function automatic logic [15:0] sat_inc16(input logic [15:0] v);
    sat_inc16 = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction : sat_inc16

  ctc_tick u_tick (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .tick_out(tick)
  );

  ctc_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in({host_cc1_in, ext2_trig_in, ext1_trig_in}),
    .sync_out(pins)
  );

  assign trig_mode = ctrl[CTRL_TRIGGERED];
  assign src = ctc_src_t'(ctrl[CTRL_SRC_LSB +: 3]);
  assign stb_mode = ctc_stb_t'(ctrl[CTRL_STROBE_LSB +: 2]);
  assign wr_en = psel_in && penable_in && pwrite_in && pready_out;
  assign deb_busy = (deb_us < debounce_us);
  assign more_frames = ctrl[CTRL_ENDLESS] || (frame_cnt < frames);

  // apb setup phase prepares read data; access completes with no wait state
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
      if (psel_in && !penable_in && !pwrite_in) begin
        if (paddr_in == OFS_CTRL) begin
          prdata_out <= {22'h000000, ctrl};
        end else if (paddr_in == OFS_DEBOUNCE) begin
          prdata_out <= {16'h0000, debounce_us};
        end else if (paddr_in == OFS_GLITCH) begin
          prdata_out <= {16'h0000, glitch_us};
        end else if (paddr_in == OFS_EXP_DELAY) begin
          prdata_out <= {8'h00, exp_delay_us};
        end else if (paddr_in == OFS_FRAMES) begin
          prdata_out <= {16'h0000, frames};
        end else if (paddr_in == OFS_STROBE_DELAY) begin
          prdata_out <= {8'h00, strobe_delay_us};
        end else if (paddr_in == OFS_EXP_TIME) begin
          prdata_out <= {8'h00, exp_time_us};
        end else if (paddr_in == OFS_STATUS) begin
          prdata_out <= {frame_cnt, 12'h000, deb_busy, st, trig_ready_out};
        end else if (paddr_in != OFS_SW_TRIG) begin
          pslverr_out <= 1'b1; // unmapped address answers with an error
        end
      end else if (psel_in && !penable_in) begin
        pslverr_out <= (paddr_in > OFS_STATUS) || (paddr_in[1:0] != 2'b00);
      end
    end
  end

  // register writes land on the access edge; frames outside 1..65530 are clamped
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl <= CTRL_RESET;
      debounce_us <= 16'h0000;
      glitch_us <= 16'h0000;
      exp_delay_us <= 24'h000000;
      frames <= FRAMES_RESET;
      strobe_delay_us <= 24'h000000;
      exp_time_us <= EXP_TIME_RESET;
      sw_pulse <= 1'b0;
    end else begin
      sw_pulse <= 1'b0;
      if (wr_en) begin
        if (paddr_in == OFS_CTRL) begin
          ctrl <= pwdata_in[CTRL_BITS-1:0];
        end else if (paddr_in == OFS_DEBOUNCE) begin
          debounce_us <= pwdata_in[15:0];
        end else if (paddr_in == OFS_GLITCH) begin
          glitch_us <= pwdata_in[15:0];
        end else if (paddr_in == OFS_EXP_DELAY) begin
          exp_delay_us <= pwdata_in[23:0];
        end else if (paddr_in == OFS_FRAMES) begin
          if (pwdata_in[15:0] == 16'h0000) begin
            frames <= FRAMES_RESET;
          end else if (pwdata_in[15:0] > FRAMES_MAX) begin
            frames <= FRAMES_MAX;
          end else begin
            frames <= pwdata_in[15:0];
          end
        end else if (paddr_in == OFS_STROBE_DELAY) begin
          strobe_delay_us <= pwdata_in[23:0];
        end else if (paddr_in == OFS_EXP_TIME) begin
          exp_time_us <= pwdata_in[23:0];
        end else if (paddr_in == OFS_SW_TRIG) begin
          sw_pulse <= pwdata_in[0];
        end
      end
    end
  end

  // source mux and edge polarity: falling edge is handled by inverting the level
  always_comb begin
    case (src)
      CTC_SRC_EXT1: lvl = pins[0];
      CTC_SRC_EXT2: lvl = pins[1];
      CTC_SRC_HOST: lvl = pins[2];
      CTC_SRC_PGEN: lvl = pulse_gen_in;
      default: lvl = 1'b0;
    endcase
    lvl = lvl ^ ctrl[CTRL_FALLING];
  end

  // glitch filter: width counted from the active edge, qualified once long enough
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lvl_prev <= 1'b0;
      pend <= 1'b0;
      wid_us <= 16'h0000;
    end else begin
      lvl_prev <= lvl;
      if (lvl && !lvl_prev) begin
        pend <= 1'b1;
        wid_us <= 16'h0000;
      end else begin
        if (!lvl || qual) begin
          pend <= 1'b0;
        end
        if (lvl && tick) begin
          wid_us <= sat_inc16(wid_us);
        end
      end
    end
  end

  assign qual = pend && lvl && (wid_us >= glitch_us);
  assign trig_ev = trig_mode && ((src == CTC_SRC_SW) ? sw_pulse : qual);
  assign accept = trig_ev && !deb_busy && ((st == CTC_IDLE) || ctrl[CTRL_ACCEPT]);

  // debounce timer restarts at each accepted trigger
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      deb_us <= 16'hffff;
    end else if (accept) begin
      deb_us <= 16'h0000;
    end else if (tick) begin
      deb_us <= sat_inc16(deb_us);
    end
  end

  // trigger cycle sequencer
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= CTC_IDLE;
      cyc_us <= 24'h000000;
      exp_us <= 24'h000000;
      frame_cnt <= 16'h0000;
      exposure_out <= 1'b0;
      readout_start_out <= 1'b0;
    end else begin
      readout_start_out <= 1'b0;
      if (tick) begin
        cyc_us <= sat_inc24(cyc_us);
        exp_us <= sat_inc24(exp_us);
      end
      if (accept) begin
        // the filter already spent the pulse width since the edge
        st <= CTC_DELAY;
        cyc_us <= (src == CTC_SRC_SW) ? 24'h000000 : {8'h00, wid_us};
        frame_cnt <= 16'h0000;
        exposure_out <= 1'b0;
      end else begin
        case (st)
          CTC_IDLE: begin
            if (!trig_mode) begin
              st <= CTC_EXPOSE;
              exp_us <= 24'h000000;
              exposure_out <= 1'b1;
            end
          end
          CTC_DELAY: begin
            if (cyc_us >= exp_delay_us) begin
              st <= CTC_EXPOSE;
              exp_us <= 24'h000000;
              exposure_out <= 1'b1;
            end
          end
          CTC_EXPOSE: begin
            if (exp_us >= exp_time_us) begin
              exposure_out <= 1'b0;
              readout_start_out <= 1'b1;
              frame_cnt <= sat_inc16(frame_cnt);
              if (ctrl[CTRL_FAST] && trig_mode) begin
                st <= CTC_IDLE;
              end else begin
                st <= CTC_READ;
              end
            end
          end
          default: begin
            if (readout_done_in) begin
              if (!trig_mode || more_frames) begin
                st <= CTC_EXPOSE;
                exp_us <= 24'h000000;
                exposure_out <= 1'b1;
              end else begin
                st <= CTC_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // ready is registered so it comes from a flip-flop
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trig_ready_out <= 1'b0;
    end else begin
      trig_ready_out <= trig_mode && (st == CTC_IDLE) && !deb_busy;
    end
  end

  // delayed trigger replays the accepted pulse width once the exposure delay expires
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_live <= 1'b0;
      held_w <= 16'h0000;
      dly_on <= 1'b0;
      dly_cnt <= 16'h0000;
      trig_delayed_out <= 1'b0;
    end else begin
      if (accept) begin
        acc_live <= (src != CTC_SRC_SW);
        held_w <= 16'h0001;
        dly_on <= 1'b1;
        dly_cnt <= 16'h0000;
        trig_delayed_out <= 1'b0;
      end else begin
        if (acc_live && lvl) begin
          held_w <= (wid_us == 16'h0000) ? 16'h0001 : wid_us;
        end else begin
          acc_live <= 1'b0;
        end
        if (dly_on && cyc_us >= exp_delay_us) begin
          trig_delayed_out <= (dly_cnt < held_w);
          if (tick) begin
            dly_cnt <= sat_inc16(dly_cnt);
          end
          if (dly_cnt >= held_w) begin
            dly_on <= 1'b0;
          end
        end else begin
          trig_delayed_out <= 1'b0;
        end
      end
    end
  end

  // strobes fire once per trigger after their own delay; a restart re-arms them
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stb_armed <= 1'b0;
      stb_on <= 1'b0;
      stb_cnt <= 16'h0000;
      strobe1_out <= 1'b0;
      strobe2_out <= 1'b0;
    end else begin
      if (accept) begin
        stb_armed <= 1'b1;
        stb_on <= 1'b0;
      end else if (stb_armed && cyc_us >= strobe_delay_us) begin
        stb_armed <= 1'b0;
        stb_on <= 1'b1;
        stb_cnt <= 16'h0000;
      end else if (stb_on) begin
        if (tick) begin
          stb_cnt <= sat_inc16(stb_cnt);
        end
        if (stb_cnt >= STROBE_WIDTH_US) begin
          stb_on <= 1'b0;
        end
      end
      strobe1_out <= stb_on && !accept && ((stb_mode == CTC_STB_ONE) || (stb_mode == CTC_STB_BOTH));
      strobe2_out <= stb_on && !accept && ((stb_mode == CTC_STB_TWO) || (stb_mode == CTC_STB_BOTH));
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  property p_ready;
    trig_ready_out |-> $past(st == CTC_IDLE) && $past(trig_mode) && !$past(deb_busy);
  endproperty
  a_ready: assert property (p_ready) else $error("ready shown while busy");

  property p_freerun;
    !trig_mode |-> !accept;
  endproperty
  a_freerun: assert property (p_freerun) else $error("trigger accepted in free-run");

  property p_ignore;
    (st != CTC_IDLE) && !ctrl[CTRL_ACCEPT] |-> !accept;
  endproperty
  a_ignore: assert property (p_ignore) else $error("overlap trigger not ignored");

  property p_restart;
    accept && (st != CTC_IDLE) |=> (st == CTC_DELAY) && (frame_cnt == 16'h0000) && !exposure_out;
  endproperty
  a_restart: assert property (p_restart) else $error("overlap accept did not restart");

  property p_debounce;
    accept && (debounce_us != 16'h0000) |=> !accept [*8];
  endproperty
  a_debounce: assert property (p_debounce) else $error("trigger inside debounce time");

  property p_delay;
    (st == CTC_DELAY) && (cyc_us < exp_delay_us) && !accept |=> !exposure_out;
  endproperty
  a_delay: assert property (p_delay) else $error("exposure before its delay");

  property p_no_overlap;
    (st == CTC_READ) |-> !exposure_out;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("exposure during standard readout");

  property p_readout;
    readout_start_out |-> $past(exposure_out) && !exposure_out;
  endproperty
  a_readout: assert property (p_readout) else $error("readout not after exposure end");

  property p_strobe_off;
    (stb_mode == CTC_STB_OFF) [*2] |-> !strobe1_out && !strobe2_out;
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("strobe while strobe mode off");

  property p_frames;
    (st == CTC_READ) && readout_done_in && trig_mode && !ctrl[CTRL_ENDLESS] && (frame_cnt >= frames) && !accept
      |=> (st == CTC_IDLE) && !exposure_out;
  endproperty
  a_frames: assert property (p_frames) else $error("extra frame after count reached");
endmodule : ctc_trigger_ctrl

// ### src/ctc_pkg.sv
// constants shared by the camera trigger controller
package ctc_pkg;
  // clock and tick timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
  // width of every strobe pulse, in microseconds
  localparam logic [15:0] STROBE_WIDTH_US = 16'h0002;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DEBOUNCE = 8'h04;
  localparam logic [7:0] OFS_GLITCH = 8'h08;
  localparam logic [7:0] OFS_EXP_DELAY = 8'h0c;
  localparam logic [7:0] OFS_FRAMES = 8'h10;
  localparam logic [7:0] OFS_STROBE_DELAY = 8'h14;
  localparam logic [7:0] OFS_EXP_TIME = 8'h18;
  localparam logic [7:0] OFS_SW_TRIG = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // control register fields
  localparam int CTRL_TRIGGERED = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam int CTRL_FAST = 4;
  localparam int CTRL_FALLING = 5;
  localparam int CTRL_ACCEPT = 6;
  localparam int CTRL_STROBE_LSB = 7;
  localparam int CTRL_ENDLESS = 9;
  localparam int CTRL_BITS = 10;
  // reset values and the frame count limit
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [15:0] FRAMES_RESET = 16'h0001;
  localparam logic [23:0] EXP_TIME_RESET = 24'h000064;
  localparam logic [15:0] FRAMES_MAX = 16'hfffa;
  // trigger sources
  typedef enum logic [2:0] {
    CTC_SRC_EXT1 = 3'b000,
    CTC_SRC_EXT2 = 3'b001,
    CTC_SRC_PGEN = 3'b010,
    CTC_SRC_HOST = 3'b011,
    CTC_SRC_SW = 3'b100
  } ctc_src_t;
  // strobe output selection
  typedef enum logic [1:0] {
    CTC_STB_OFF = 2'b00,
    CTC_STB_ONE = 2'b01,
    CTC_STB_TWO = 2'b10,
    CTC_STB_BOTH = 2'b11
  } ctc_stb_t;
  // trigger cycle states
  typedef enum logic [1:0] {
    CTC_IDLE = 2'b00,
    CTC_DELAY = 2'b01,
    CTC_EXPOSE = 2'b10,
    CTC_READ = 2'b11
  } ctc_state_t;
endpackage : ctc_pkg

// ### src/ctc_tick.sv
// one-microsecond enable tick divided from the system clock
module ctc_tick (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  output logic tick_out
);
  import ctc_pkg::*;
  logic [6:0] div;
  // divider wraps every microsecond and pulses the tick for one cycle
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div <= 7'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (div == TICK_LAST);
      div <= (div == TICK_LAST) ? 7'h00 : div + 7'h01;
    end
  end
endmodule : ctc_tick

// ### src/ctc_sync.sv
// two-stage synchroniser for the asynchronous trigger pins
module ctc_sync (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);
  logic [2:0] meta;
  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta <= 3'h0;
      sync_out <= 3'h0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : ctc_sync

// ### dv/ctc_far_model.sv
// far-side model: trigger pins and the sensor readout answer
module ctc_far_model (
  input wire logic clk_sys_in,
  input wire logic readout_start_in,
  output logic [3:0] pins_out,
  output logic readout_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int rd_us = 2;
  int rd_cnt = 0;
  logic idle_lvl = 1'b0;
  initial pins_out = 4'h0;
  initial readout_done_out = 1'b0;
  // readout lasts rd_us microseconds, then one done pulse; a new start reloads it
  always @(posedge clk_sys_in) begin
    readout_done_out <= (rd_cnt == 1);
    if (readout_start_in) rd_cnt <= rd_us * 100;
    else if (rd_cnt > 0) rd_cnt <= rd_cnt - 1;
  end
  // one pulse of width_us microseconds on the chosen pin; the bench sets the spacing each test needs
  task automatic pulse(input int pin, input int width_us);
    @(posedge clk_sys_in);
    pins_out[pin] <= ~idle_lvl;
    repeat (width_us * 100) @(posedge clk_sys_in);
    pins_out[pin] <= idle_lvl;
  endtask : pulse
  // resting level of every pin; pulses go to the opposite level
  task automatic set_idle(input logic lvl);
    @(posedge clk_sys_in);
    idle_lvl = lvl;
    pins_out <= {4{lvl}};
  endtask : set_idle
endmodule : ctc_far_model

// ### dv/ctc_trigger_ctrl_test.sv
// self-checking bench for the camera trigger controller
module ctc_trigger_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ctc_pkg::*;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, expo, rds, stb1, stb2, rdy_o, tdly, rdone;
  logic [3:0] pins;
  logic [4:0] prev = 5'h00;
  logic std_chk = 1'b0;
  logic rd_pend = 1'b0;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int n_exp, n_rs, n_s1, n_s2, n_dly;

  ctc_trigger_ctrl ctc_trigger_ctrl_inst (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .ext1_trig_in(pins[0]), .ext2_trig_in(pins[1]),
    .host_cc1_in(pins[3]), .pulse_gen_in(pins[2]), .readout_done_in(rdone), .exposure_out(expo),
    .readout_start_out(rds), .strobe1_out(stb1), .strobe2_out(stb2), .trig_ready_out(rdy_o),
    .trig_delayed_out(tdly)
  );
  ctc_far_model ctc_far_model_inst (
    .clk_sys_in(clk_sys_in), .readout_start_in(rds), .pins_out(pins), .readout_done_out(rdone)
  );

  // 100 MHz clock
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // edge counters, readout-overlap watch and the hang limit
  always @(posedge clk_sys_in) begin
    prev <= {expo, rds, stb1, stb2, tdly};
    n_exp += int'(expo & ~prev[4]);
    n_rs += int'(rds & ~prev[3]);
    n_s1 += int'(stb1 & ~prev[2]);
    n_s2 += int'(stb2 & ~prev[1]);
    n_dly += int'(tdly & ~prev[0]);
    rd_pend <= rds | (rd_pend & ~rdone);
    if (std_chk && expo && !prev[4] && rd_pend) chk("exposure in readout", 0, 1);
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp_v, input logic [31:0] got);
    checked++;
    if (got !== exp_v) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp_v, got);
    end
  endtask : chk

  // one apb transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    int n;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1);
    // the slave answers in the first access cycle, so no wait state is expected
    chk("apb wait", 1, n);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
    chk("write error", 0, {31'h0, e});
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp_d, input logic exp_e);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk($sformatf("read %h", a), exp_d, d);
    chk($sformatf("error %h", a), {31'h0, exp_e}, {31'h0, e});
  endtask : rdc

  task automatic us(input int n);
    repeat (n * 100) @(posedge clk_sys_in);
  endtask : us

  task automatic clr();
    n_exp = 0;
    n_rs = 0;
    n_s1 = 0;
    n_s2 = 0;
    n_dly = 0;
  endtask : clr

  // source code 4 is the software command, 0 to 3 are the pins
  task automatic fire(input int src, input int w);
    if (src == 4) wr(OFS_SW_TRIG, 32'h1);
    else ctc_far_model_inst.pulse(src, w);
  endtask : fire

  // triggered mode with extra control bits, then wait until a trigger is welcome
  task automatic cfg(input logic [31:0] c);
    int n;
    wr(OFS_CTRL, c | 32'h1);
    n = 0;
    while (rdy_o !== 1'b1 && n < 30000) begin
      @(posedge clk_sys_in);
      n++;
    end
    chk("ready", 1, rdy_o);
  endtask : cfg

  task automatic stop_test();
    $display("mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  initial begin
    repeat (5) @(posedge clk_sys_in);
    chk("outputs in reset", 0, {expo, rds, stb1, stb2, rdy_o, tdly, pready});
    repeat (5) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rdc(OFS_CTRL, 32'(CTRL_RESET), 1'b0);
    rdc(OFS_FRAMES, 32'(FRAMES_RESET), 1'b0);
    rdc(OFS_EXP_TIME, 32'(EXP_TIME_RESET), 1'b0);
    rdc(8'h24, 32'h0, 1'b1);
    rdc(8'h02, 32'h0, 1'b1);
    wr(OFS_FRAMES, 32'h0);
    rdc(OFS_FRAMES, 32'h1, 1'b0);
    wr(OFS_FRAMES, 32'hffff);
    rdc(OFS_FRAMES, 32'(FRAMES_MAX), 1'b0);
    wr(OFS_FRAMES, 32'h1);
    wr(OFS_EXP_TIME, 32'h3);
    // free run rolls on its own; pins must not raise strobes
    wr(OFS_CTRL, 32'(3 << CTRL_STROBE_LSB));
    clr();
    fire(0, 2);
    us(20);
    chk("free-run exposures", 1, n_exp > 2);
    chk("free-run strobes", 0, n_s1 + n_s2 + n_dly);
    chk("free-run ready", 0, rdy_o);
    // every source: a pulse on another input is ignored, the chosen one fires
    for (int s = 0; s < 5; s++) begin
      cfg(32'(s << CTRL_SRC_LSB));
      clr();
      fire((s + 1) % 4, 2);
      us(5);
      chk("other source", 0, n_exp);
      fire(s, 2);
      us(5);
      chk("chosen source", 1, n_exp);
    end
    // low-going pulses: rising mode waits for the end, falling mode starts at once
    ctc_far_model_inst.set_idle(1'b1);
    // pick the high pin while in free run, so the source switch is not seen as an edge
    wr(OFS_CTRL, 32'h0);
    cfg(32'h0);
    clr();
    fire(0, 20);
    chk("rising edge", 0, n_exp);
    us(6);
    cfg(32'(1 << CTRL_FALLING));
    clr();
    fire(0, 20);
    chk("falling edge", 1, n_exp);
    cfg(32'h0);
    ctc_far_model_inst.set_idle(1'b0);
    // glitch filter at 5 us
    wr(OFS_GLITCH, 32'h5);
    cfg(32'h0);
    clr();
    fire(0, 3);
    us(10);
    chk("short pulse", 0, n_exp);
    fire(0, 8);
    us(5);
    chk("long pulse", 1, n_exp);
    wr(OFS_GLITCH, 32'h0);
    // strobe modes with 10 us strobe delay and 20 us exposure delay
    wr(OFS_STROBE_DELAY, 32'd10);
    wr(OFS_EXP_DELAY, 32'd20);
    rdc(OFS_EXP_DELAY, 32'd20, 1'b0);
    for (int m = 0; m < 4; m++) begin
      cfg(32'(m << CTRL_STROBE_LSB));
      clr();
      fire(0, 1);
      us(7);
      chk("early strobe", 0, n_s1 + n_s2);
      chk("early exposure", 0, n_exp + n_dly);
      us(6);
      chk("strobe one", m & 1, n_s1);
      chk("strobe two", m >> 1, n_s2);
      us(11);
      chk("delayed exposure", 1, n_exp);
      chk("delayed trigger", 1, n_dly);
    end
    wr(OFS_EXP_DELAY, 32'h0);
    // three frames per trigger, each waiting for its readout
    ctc_far_model_inst.rd_us = 4;
    wr(OFS_FRAMES, 32'h3);
    cfg(32'h0);
    clr();
    std_chk = 1'b1;
    fire(0, 1);
    us(40);
    chk("frames", 3, n_exp);
    chk("readouts", 3, n_rs);
    // status: three frames done, idle, debounce over, ready
    rdc(OFS_STATUS, 32'h00030001, 1'b0);
    std_chk = 1'b0;
    wr(OFS_FRAMES, 32'h1);
    // second trigger 11 us into a 30 us exposure: ignore vs accept
    wr(OFS_EXP_TIME, 32'd30);
    for (int a = 0; a < 2; a++) begin
      cfg(32'(a << CTRL_ACCEPT));
      clr();
      fire(0, 1);
      us(10);
      fire(0, 1);
      us(23);
      chk("exposure after overlap", a, expo);
    end
    wr(OFS_EXP_TIME, 32'h3);
    // debounce blocks a retrigger and holds ready low
    wr(OFS_DEBOUNCE, 32'd20);
    cfg(32'(1 << CTRL_ACCEPT));
    clr();
    fire(0, 1);
    us(9);
    chk("ready in debounce", 0, rdy_o);
    fire(0, 1);
    us(5);
    chk("debounced", 1, n_exp);
    us(10);
    chk("ready after debounce", 1, rdy_o);
    wr(OFS_DEBOUNCE, 32'h0);
    // fast mode exposes again while a long readout is still running
    ctc_far_model_inst.rd_us = 15;
    cfg(32'(1 << CTRL_FAST));
    clr();
    fire(0, 1);
    us(6);
    fire(0, 1);
    us(5);
    chk("fast overlap", 2, n_exp);
    // endless frames keep going after one trigger
    ctc_far_model_inst.rd_us = 2;
    cfg(32'(1 << CTRL_ENDLESS));
    clr();
    fire(0, 1);
    us(40);
    chk("endless frames", 1, n_exp > 4);
    stop_test();
  end
endmodule : ctc_trigger_ctrl_test
